// File: shared/dvr_consts.vh
// Constants for the dynamic code reference stepper.
`ifndef DVR_CONSTS_VH
`define DVR_CONSTS_VH
`define DVR_SAMPLES_PER_CYCLE 3'd6
`define DVR_MATCH_COUNT 2'd3
`define DVR_SHUTDOWN_DELAY 2'd2
`define DVR_MODE_SIX 2'd0
`define DVR_MODE_FIVE_A 2'd1
`define DVR_MODE_FIVE_B 2'd2
`define DVR_NOLOAD_SIX_A 6'h3f
`define DVR_NOLOAD_SIX_B 6'h3e
`define DVR_NOLOAD_FIVE 5'h1f
`define DVR_REF_WIDTH 6
`define DVR_REF_RESET 6'h00
`endif

// File: src/dvr_reference_stepper.v
// Reference stepper that follows processor voltage identification code changes.
`timescale 1ns/1ps
`include "dvr_consts.vh"
module dvr_reference_stepper (
   input  wire       ref_clk,
   input  wire       rst,
   input  wire [1:0] codeMode,
   input  wire [5:0] voltage_id_code,
   input  wire       sampleTick,
   input  wire       phaseStart,
   input  wire       phaseHalf,
   output reg  [5:0] referenceCode,
   output reg  [5:0] targetCode,
   output reg        slewing,
   output reg        noLoad,
   output reg        shutdownTrip,
   output reg        modulatorOff,
   output reg        softStartRequest
);

   // Slew states for the five-bit modes.
   localparam [1:0] SLEW_IDLE = 2'd0;
   localparam [1:0] SLEW_WAIT = 2'd1;
   localparam [1:0] SLEW_MOVE = 2'd2;

   // Registered state.
   reg  [5:0] lastSample;
   reg  [1:0] matchCount;
   reg  [1:0] delayCount;
   reg  [1:0] slewState;

   // Next values.
   reg  [5:0] next_lastSample;
   reg  [1:0] next_matchCount;
   reg        sixAccept;
   reg  [1:0] next_slewState;
   reg  [5:0] next_targetCode;
   reg  [5:0] next_referenceCode;
   reg        next_noLoad;
   reg  [1:0] next_delayCount;
   reg        next_shutdownTrip;
   reg        next_modulatorOff;
   reg        next_softStartRequest;

   wire       sixMode;
   wire [5:0] codeIn;
   wire       sixNoLoad;
   wire       fiveNoLoad;
   wire       isNoLoad;
   wire       codeNew;
   wire       atTarget;
   wire       stepUp;
   wire       shutdownDue;
   wire       next_slewing;

   // Six-bit mode reads all six inputs; five-bit modes ignore the top bit.
   assign sixMode      = (codeMode == `DVR_MODE_SIX);
   assign codeIn       = sixMode ? voltage_id_code : {1'b0, voltage_id_code[4:0]};
   assign sixNoLoad    = (voltage_id_code == `DVR_NOLOAD_SIX_A) ||
                         (voltage_id_code == `DVR_NOLOAD_SIX_B);
   assign fiveNoLoad   = (voltage_id_code[4:0] == `DVR_NOLOAD_FIVE);
   assign isNoLoad     = sixMode ? sixNoLoad : fiveNoLoad;
   // No-load codes never become a reference target.
   assign codeNew      = (codeIn != targetCode) && !isNoLoad;
   assign atTarget     = (referenceCode == targetCode);
   assign stepUp       = (referenceCode < targetCode);
   assign shutdownDue  = noLoad && phaseStart && (delayCount >= `DVR_SHUTDOWN_DELAY - 2'd1);
   assign next_slewing = (next_slewState == SLEW_MOVE);

   // Counts identical samples of the six-bit code.
   always @* begin
      next_lastSample = lastSample;
      next_matchCount = matchCount;
      sixAccept       = 1'b0;
      if (sixMode && sampleTick) begin
         next_lastSample = codeIn;
         if (codeIn != lastSample) begin
            next_matchCount = 2'd1;
         end else if (matchCount != `DVR_MATCH_COUNT) begin
            next_matchCount = matchCount + 2'd1;
            if (matchCount == `DVR_MATCH_COUNT - 2'd1) begin
               sixAccept = 1'b1;
            end
         end
      end
   end

   // Chooses the target and moves the reference.
   always @* begin
      next_slewState     = slewState;
      next_targetCode    = targetCode;
      next_referenceCode = referenceCode;
      if (sixMode) begin
         next_slewState = SLEW_IDLE;
         if (sixAccept && codeNew) begin
            next_targetCode    = codeIn;
            next_referenceCode = codeIn;
         end
      end else if (phaseStart && codeNew) begin
         next_targetCode = codeIn;
         next_slewState  = SLEW_WAIT;
      end else begin
         case (slewState)
            SLEW_IDLE: begin
               next_slewState = SLEW_IDLE;
            end
            SLEW_WAIT: begin
               if (phaseHalf) begin
                  next_slewState = SLEW_MOVE;
               end
            end
            SLEW_MOVE: begin
               if (phaseHalf) begin
                  if (atTarget) begin
                     next_slewState = SLEW_IDLE;
                  end else if (stepUp) begin
                     next_referenceCode = referenceCode + 6'h01;
                  end else begin
                     next_referenceCode = referenceCode - 6'h01;
                  end
               end
            end
            default: begin
               next_slewState = SLEW_IDLE;
            end
         endcase
      end
   end

   // Tracks no-load codes, the shutdown delay and the restart pulse.
   always @* begin
      next_noLoad           = noLoad;
      next_delayCount       = delayCount;
      next_shutdownTrip     = shutdownTrip;
      next_modulatorOff     = modulatorOff;
      next_softStartRequest = 1'b0;
      if (isNoLoad) begin
         next_noLoad = 1'b1;
         if (!noLoad) begin
            next_delayCount = 2'd0;
         end else if (phaseStart && delayCount != `DVR_SHUTDOWN_DELAY) begin
            next_delayCount = delayCount + 2'd1;
         end
         if (shutdownDue) begin
            next_shutdownTrip = 1'b1;
            next_modulatorOff = 1'b1;
         end
      end else if (noLoad) begin
         next_noLoad           = 1'b0;
         next_shutdownTrip     = 1'b0;
         next_modulatorOff     = 1'b0;
         next_softStartRequest = 1'b1;
      end
   end

   // Sample history registers.
   always @(posedge ref_clk) begin
      if (rst) begin
         lastSample <= `DVR_REF_RESET;
         matchCount <= 2'd0;
      end else begin
         lastSample <= next_lastSample;
         matchCount <= next_matchCount;
      end
   end

   // Slew state registers.
   always @(posedge ref_clk) begin
      if (rst) begin
         slewState <= SLEW_IDLE;
         slewing   <= 1'b0;
      end else begin
         slewState <= next_slewState;
         slewing   <= next_slewing;
      end
   end

   // Target and reference registers.
   always @(posedge ref_clk) begin
      if (rst) begin
         targetCode    <= `DVR_REF_RESET;
         referenceCode <= `DVR_REF_RESET;
      end else begin
         targetCode    <= next_targetCode;
         referenceCode <= next_referenceCode;
      end
   end

   // No-load flag and delay counter.
   always @(posedge ref_clk) begin
      if (rst) begin
         noLoad     <= 1'b0;
         delayCount <= 2'd0;
      end else begin
         noLoad     <= next_noLoad;
         delayCount <= next_delayCount;
      end
   end

   // Shutdown and restart outputs.
   always @(posedge ref_clk) begin
      if (rst) begin
         shutdownTrip     <= 1'b0;
         modulatorOff     <= 1'b0;
         softStartRequest <= 1'b0;
      end else begin
         shutdownTrip     <= next_shutdownTrip;
         modulatorOff     <= next_modulatorOff;
         softStartRequest <= next_softStartRequest;
      end
   end

endmodule // dvr_reference_stepper

// File: testbench/dvr_checker_sva.sv
// Checker for the reference stepper outputs.
`timescale 1ns/1ps
module dvr_checker (
   input wire       ref_clk,
   input wire       rst,
   input wire [1:0] codeMode,
   input wire       phaseHalf,
   input wire [5:0] referenceCode,
   input wire       slewing,
   input wire       noLoad,
   input wire       shutdownTrip,
   input wire       modulatorOff,
   input wire       softStartRequest
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   property p_trip; shutdownTrip |-> noLoad && modulatorOff; endproperty
   a_trip: assert property (p_trip) else $error("trip without no-load");
   property p_wait; $rose(noLoad) |-> !shutdownTrip [*2]; endproperty
   a_wait: assert property (p_wait) else $error("shutdown too early");
   property p_pulse; softStartRequest |=> !softStartRequest; endproperty
   a_pulse: assert property (p_pulse) else $error("restart pulse too long");
   property p_step; codeMode != 2'd0 && !noLoad && !$past(noLoad) && $changed(referenceCode)
      |-> 6'(referenceCode - $past(referenceCode)) inside {6'h01, 6'h3f}; endproperty
   a_step: assert property (p_step) else $error("slew step not one code");
   property p_restart; $fell(noLoad) |-> softStartRequest; endproperty
   a_restart: assert property (p_restart) else $error("no restart pulse");
   property p_six_still; codeMode == 2'd0 |=> !slewing; endproperty
   a_six_still: assert property (p_six_still) else $error("slewing in six-bit mode");
   property p_slew_edge; codeMode != 2'd0 && $past(codeMode) != 2'd0 && $changed(referenceCode)
      |-> $past(phaseHalf); endproperty
   a_slew_edge: assert property (p_slew_edge) else $error("slew step off phase");
endmodule // dvr_checker
bind dvr_reference_stepper dvr_checker chk (.ref_clk, .rst, .codeMode, .phaseHalf,
   .referenceCode, .slewing, .noLoad, .shutdownTrip, .modulatorOff, .softStartRequest);

// File: testbench/dvr_cpu_model.sv
// Processor model that walks the six-bit code one step at a time.
`timescale 1ns/1ps
module dvr_cpu_model (
   input  wire       ref_clk,
   input  wire [5:0] goal,
   output reg  [5:0] code
);
   reg [3:0] t = 4'h0;
   initial code = 6'h00;
   always @(posedge ref_clk) begin
      t <= t + 4'h1;
      if (t == 4'h0 && code != goal) code <= code < goal ? code + 6'h01 : code - 6'h01;
   end
endmodule // dvr_cpu_model

// File: testbench/tb_dynamic_vid_reference_stepper.sv
// Testbench for the reference stepper.
`timescale 1ns/1ps
module tb_dynamic_vid_reference_stepper;
   reg         ref_clk  = 1'b0;
   reg         rst      = 1'b1;
   reg  [1:0]  codeMode = 2'h0;
   reg  [5:0]  goal     = 6'h00;
   reg  [3:0]  ph       = 4'h0;
   reg  [31:0] seed     = 32'h00000058;
   reg  [5:0]  lastRef  = 6'h00;
   wire [5:0]  cpuCode;
   wire [5:0]  vidCode;
   wire [5:0]  refC;
   wire [5:0]  tgtC;
   wire        slw;
   wire        nl;
   wire        trip;
   wire        mo;
   wire        ssr;
   int         err_total = 0;
   int         tests_run = 0;
   int         modelRef  = 0;
   int         modelQ[$];
   int         i;
   int         g;
   assign vidCode = codeMode == 2'h0 ? cpuCode : goal;
   always #50 ref_clk = ~ref_clk;
   always @(posedge ref_clk) ph <= ph == 4'hb ? 4'h0 : ph + 4'h1;
   dvr_cpu_model cpu (.ref_clk(ref_clk), .goal(goal), .code(cpuCode));
   dvr_reference_stepper dut (.ref_clk(ref_clk), .rst(rst), .codeMode(codeMode),
      .voltage_id_code(vidCode), .sampleTick(ph[0]), .phaseStart(ph == 4'h0),
      .phaseHalf(ph == 4'h6), .referenceCode(refC), .targetCode(tgtC), .slewing(slw),
      .noLoad(nl), .shutdownTrip(trip), .modulatorOff(mo), .softStartRequest(ssr));
   function automatic [31:0] xorshift(input [31:0] s);
      reg [31:0] x;
      begin
         x = s ^ (s << 13);
         x = x ^ (x >> 17);
         xorshift = x ^ (x << 5);
      end
   endfunction
   task automatic check(input string what, input logic [5:0] seen, input logic [5:0] expected);
      tests_run++;
      if (seen !== expected) begin
         err_total++;
         $display("Error %s expected %h seen %h", what, expected, seen);
      end
   endtask
   // The model walks one code at a time from its reference to the new target.
   task automatic plan_walk(input int target);
      while (modelRef != target) begin
         modelRef = modelRef < target ? modelRef + 1 : modelRef - 1;
         modelQ.push_back(modelRef);
      end
   endtask
   // Every reference change is compared with the next value of the model.
   always @(negedge ref_clk) begin
      if (!rst && refC !== lastRef) begin
         if (modelQ.size() == 0) begin
            check("referenceCode step", refC, lastRef);
         end else begin
            check("referenceCode step", refC, 6'(modelQ.pop_front()));
         end
         lastRef = refC;
      end
   end
   task complete_run;
      $display("errors %0d checks %0d", err_total, tests_run);
      if (err_total == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge ref_clk);
      rst <= 0;
      for (i = 0; i < 8; i++) begin
         @(posedge ref_clk);
         seed = xorshift(seed);
         g = i < 4 ? seed[5:0] % 60 : seed[4:0] % 31;
         codeMode <= i < 4 ? 2'h0 : 2'(1 + i % 2);
         goal <= 6'(g);
         plan_walk(g);
         repeat (1100) @(posedge ref_clk);
         @(negedge ref_clk);
         check("referenceCode", refC, goal);
         check("targetCode", tgtC, goal);
         check("slewing", {5'h00, slw}, 6'h00);
         check("model queue", 6'(modelQ.size()), 6'h00);
         check("noLoad", {5'h00, nl}, 6'h00);
      end
      @(posedge ref_clk);
      goal <= 6'h1f;
      repeat (4) @(posedge ref_clk);
      @(negedge ref_clk);
      check("noLoad", {5'h00, nl}, 6'h01);
      check("shutdownTrip", {5'h00, trip}, 6'h00);
      repeat (40) @(posedge ref_clk);
      @(negedge ref_clk);
      check("modulatorOff", {5'h00, mo}, 6'h01);
      check("shutdownTrip", {5'h00, trip}, 6'h01);
      check("referenceCode", refC, 6'(modelRef));
      @(posedge ref_clk);
      goal <= 6'h05;
      plan_walk(5);
      @(posedge ref_clk);
      @(negedge ref_clk);
      check("softStartRequest", {5'h00, ssr}, 6'h01);
      check("noLoad", {5'h00, nl}, 6'h00);
      check("modulatorOff", {5'h00, mo}, 6'h00);
      repeat (600) @(posedge ref_clk);
      @(negedge ref_clk);
      check("softStartRequest", {5'h00, ssr}, 6'h00);
      check("referenceCode", refC, 6'h05);
      check("model queue", 6'(modelQ.size()), 6'h00);
      complete_run;
   end
   // The tests need about 9,500 cycles; the watchdog allows 12,000.
   initial begin
      repeat (12000) @(posedge ref_clk);
      err_total++;
      complete_run;
   end
endmodule // tb_dynamic_vid_reference_stepper
